// ===== logic/lcc_core.sv
// Command control of the matrix LCD driver with a Wishbone register slave
// Operation
// - Full-set-only writes ignored while select is 0
// - Basic-only writes ignored while select is 1
// - Icon mode limits start line to 78
// - Icon mode limits initial row to 78
// - Basic set uses one fixed temperature coefficient
// - Four rows only at rates 1:64, 1:80
// - Partial size steps 8, or 16 with icons
// - Generator power 00 off, else on
// - Oscillator bit gates oscillator and generator
// - Display off, all lit: ground, stop all
// - All lit overrides inverse video
// - Power save grounds and stops oscillator, generator, display
// - Calibration runs while its bit is 1
// - Column and bank addresses with wrap limits
// - Start line and initial row, reset zero
// - Partial field 1:16 to 1:80, variant reset
// - Status shows busy, display-on, init underway
// - Status shows maker code and row variant
// - Basic pump codes give 4 to 7
// - Trim input read as two's complement
// - Program and offset reset to zero
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module lcc_core
	import lcc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [5:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic [31:0]           wb_dat_o,
	output logic                  wb_ack_o,
	input  wire logic [2:0]       maker_code_field,
	input  wire logic             row_count_variant,
	input  wire logic [4:0]       voltage_trim_input,
	input  wire logic             ram_write_strobe,
	output lcc_pkg::lcc_mode_s    mode,
	output logic                  frame_cal_run,
	output logic                  rows_p4,
	output logic [2:0]            temp_coefficient,
	output logic [2:0]            pump_factor,
	output logic [7:0]            lcd_voltage_program,
	output logic [2:0]            voltage_program_offset,
	output logic signed [5:0]     trim_value,
	output logic [6:0]            col_addr,
	output logic [3:0]            bank_addr
);
	import lcc_pkg::*;

	logic [31:0] ctrl_q, addr_q, line_q, basic_q, full_q;
	logic [31:0] dat_q;
	logic        ack_q;
	logic [7:0]  init_cnt_q;
	logic        init_q;
	logic [2:0]  mk_s1_q, mk_s2_q;
	logic        var_s1_q, var_s2_q;
	logic [4:0]  trim_s1_q, trim_s2_q;
	logic        ramw_s1_q, ramw_s2_q;
	logic        full_set;
	logic        icon_on;
	logic        wr;
	lcc_vseq_e   vs_q;
	logic [7:0]  vprog_q;
	logic [2:0]  voltage_program_offset_q;
	lcc_mode_s   mode_q;
	logic        fcal_q, p4_q;
	logic [2:0]  tc_q, pump_q;
	logic signed [5:0] trim_q;
	logic [6:0]  col_q;
	logic [3:0]  bank_q;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [6:0] clamp_line(input logic [6:0] v,
		input logic icon);
		clamp_line = (icon && v > ICON_LINE_MAX) ? ICON_LINE_MAX : v;
	endfunction

	function automatic logic [6:0] fit_part(input logic [6:0] v,
		input logic icon);
		logic [6:0] r;
		r = v & (icon ? STEP16_MSK : STEP8_MSK);
		if (r < PART_16) begin
			r = PART_16;
		end
		if (r > PART_80) begin
			r = PART_80;
		end
		return r;
	endfunction

	assign full_set = ctrl_q[CT_FULL];
	assign icon_on  = full_q[FS_ICON];
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && !init_q;

	// Synchronisers for identification pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mk_s1_q   <= 3'h0;
			mk_s2_q   <= 3'h0;
			var_s1_q  <= 1'b0;
			var_s2_q  <= 1'b0;
		end else begin
			mk_s1_q   <= maker_code_field;
			mk_s2_q   <= mk_s1_q;
			var_s1_q  <= row_count_variant;
			var_s2_q  <= var_s1_q;
		end
	end

	// Synchronisers for trim and write strobe pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trim_s1_q <= 5'h00;
			trim_s2_q <= 5'h00;
			ramw_s1_q <= 1'b0;
			ramw_s2_q <= 1'b0;
		end else begin
			trim_s1_q <= voltage_trim_input;
			trim_s2_q <= trim_s1_q;
			ramw_s1_q <= ram_write_strobe;
			ramw_s2_q <= ramw_s1_q;
		end
	end

	// Start-up sequence after reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			init_cnt_q <= INIT_CYC;
			init_q     <= 1'b1;
		end else if (init_cnt_q != 8'h00) begin
			init_cnt_q <= init_cnt_q - 8'h01;
		end else begin
			init_q <= 1'b0;
		end
	end

	// Bus answer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i) begin
				unique case (wb_adr_i)
					ADR_CTRL:   dat_q <= ctrl_q;
					ADR_ADDR:   dat_q <= addr_q;
					ADR_LINE:   dat_q <= line_q;
					ADR_BASIC:  dat_q <= basic_q;
					ADR_FULL:   dat_q <= full_q;
					ADR_STATUS: begin
						dat_q <= 32'h0000_0000;
						dat_q[ST_BUSY]  <= init_q;
						dat_q[ST_DON]   <= mode_q.disp_on;
						dat_q[ST_INIT]  <= init_q;
						dat_q[ST_MAKER +: 3] <= mk_s2_q;
						dat_q[ST_VAR]   <= var_s2_q;
						dat_q[ST_TRIM +: 6]  <= trim_q;
					end
					default:    dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RST;
		end else if (wr && wb_adr_i == ADR_CTRL) begin
			ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_037F;
		end
	end

	// Address register and write pointer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			addr_q <= {4'h0, BANK_MAX_RST, 1'b0, COL_MAX_RST, 16'h0000};
		end else if (wr && wb_adr_i == ADR_ADDR) begin
			addr_q <= merge(addr_q, wb_dat_i, wb_sel_i) & 32'h0F7F_0F7F;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			col_q  <= 7'h00;
			bank_q <= 4'h0;
		end else if (wr && wb_adr_i == ADR_ADDR) begin
			col_q  <= wb_dat_i[AD_COL +: 7];
			bank_q <= wb_dat_i[AD_BANK +: 4];
		end else if (ramw_s2_q) begin
			if (col_q >= addr_q[AD_CMAX +: 7]) begin
				col_q <= 7'h00;
				bank_q <= (bank_q >= addr_q[AD_BMAX +: 4]) ?
					4'h0 : bank_q + 4'h1;
			end else begin
				col_q <= col_q + 7'h01;
			end
		end
	end

	// Line register; partial value taken from variant at start-up
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			line_q <= 32'h0000_0000;
		end else if (init_q) begin
			line_q[LN_PART +: 7] <= var_s2_q ? PART_80 : PART_64;
		end else if (wr && wb_adr_i == ADR_LINE) begin
			line_q[LN_START +: 7] <=
				clamp_line(wb_dat_i[LN_START +: 7], icon_on);
			line_q[LN_ROW +: 7] <=
				clamp_line(wb_dat_i[LN_ROW +: 7], icon_on);
			line_q[LN_PART +: 7] <=
				fit_part(wb_dat_i[LN_PART +: 7], icon_on);
		end else if (icon_on) begin
			line_q[LN_START +: 7] <=
				clamp_line(line_q[LN_START +: 7], 1'b1);
			line_q[LN_ROW +: 7] <=
				clamp_line(line_q[LN_ROW +: 7], 1'b1);
			line_q[LN_PART +: 7] <=
				fit_part(line_q[LN_PART +: 7], 1'b1);
		end
	end

	// Basic-only settings
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			basic_q <= 32'h0000_0000;
		end else if (wr && wb_adr_i == ADR_BASIC && !full_set) begin
			basic_q <= merge(basic_q, wb_dat_i, wb_sel_i) & 32'h0000_373F;
		end
	end

	// Full-set-only settings
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			full_q <= {21'h0, FPUMP_RST, 5'h00, TC_RST};
		end else if (wr && wb_adr_i == ADR_FULL && full_set) begin
			full_q <= merge(full_q, wb_dat_i, wb_sel_i) & 32'h0000_0737;
		end
	end

	// Voltage programming sequence in basic mode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vs_q    <= VS_IDLE;
			vprog_q <= 8'h00;
			voltage_program_offset_q  <= 3'h0;
		end else if (full_set) begin
			vs_q    <= VS_IDLE;
			vprog_q <= 8'h00;
			voltage_program_offset_q  <= 3'h0;
		end else if (wr) begin
			unique case (vs_q)
				VS_IDLE: begin
					if (wb_adr_i == ADR_BASIC) begin
						vs_q <= VS_PR;
					end
				end
				VS_PR: begin
					vs_q <= (wb_adr_i == ADR_BASIC) ? VS_OFF : VS_IDLE;
				end
				VS_OFF: begin
					vprog_q <= {2'b00, basic_q[BS_VPR +: 6]};
					voltage_program_offset_q  <= basic_q[BS_VOLTAGE_PROGRAM_OFFSET +: 3];
					vs_q    <= (wb_adr_i == ADR_BASIC) ? VS_PR : VS_IDLE;
				end
			endcase
		end
	end

	// Display mode decode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= '{default: 1'b0};
			mode_q.grounded <= 1'b1;
		end else begin
			mode_q <= '{default: 1'b0};
			if (ctrl_q[CT_PSAVE]) begin
				mode_q.grounded <= 1'b1;
			end else if (!ctrl_q[CT_OSC]) begin
				mode_q.grounded <= 1'b1;
			end else if (!ctrl_q[CT_DON] && ctrl_q[CT_ALL]) begin
				mode_q.grounded <= 1'b1;
			end else begin
				mode_q.osc_run  <= 1'b1;
				mode_q.hv_en    <= ctrl_q[CT_HV +: 2] != 2'b00;
				mode_q.disp_on  <= ctrl_q[CT_DON];
				mode_q.grounded <= !ctrl_q[CT_DON];
				mode_q.all_lit  <= ctrl_q[CT_DON] && ctrl_q[CT_ALL];
				mode_q.inverse  <= ctrl_q[CT_DON] && !ctrl_q[CT_ALL]
					&& ctrl_q[CT_INV];
			end
		end
	end

	// Calibration follows its control bit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fcal_q <= 1'b0;
		end else begin
			fcal_q <= ctrl_q[CT_FCAL];
		end
	end

	// Four simultaneous rows only at rates 1:64 and 1:80
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			p4_q <= 1'b0;
		end else begin
			p4_q <= full_set && full_q[FS_MP] &&
				(line_q[LN_PART +: 7] == PART_64 ||
				line_q[LN_PART +: 7] == PART_80);
		end
	end

	// Temperature coefficient fixed in the basic set
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tc_q <= TC_FIXED;
		end else begin
			tc_q <= full_set ? full_q[FS_TC +: 3] : TC_FIXED;
		end
	end

	// Charge-pump factor of the active set
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pump_q <= FPUMP_RST;
		end else if (full_set) begin
			pump_q <= full_q[FS_PUMP +: 3];
		end else begin
			pump_q <= {1'b1, basic_q[BS_PUMP +: 2]};
		end
	end

	// Trim pins as a signed value
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trim_q <= 6'sh00;
		end else begin
			trim_q <= {trim_s2_q[4], trim_s2_q};
		end
	end

	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;
	assign mode = mode_q;
	assign frame_cal_run = fcal_q;
	assign rows_p4 = p4_q;
	assign temp_coefficient = tc_q;
	assign pump_factor = pump_q;
	assign lcd_voltage_program = vprog_q;
	assign voltage_program_offset = voltage_program_offset_q;
	assign trim_value = trim_q;
	assign col_addr = col_q;
	assign bank_addr = bank_q;
endmodule

// ===== logic/lcc_pkg.sv
// Package: offsets, fields, reset values and types of the command control
package lcc_pkg;
	localparam logic [5:0] ADR_CTRL   = 6'h00;
	localparam logic [5:0] ADR_ADDR   = 6'h04;
	localparam logic [5:0] ADR_LINE   = 6'h08;
	localparam logic [5:0] ADR_STATUS = 6'h0C;
	localparam logic [5:0] ADR_BASIC  = 6'h10;
	localparam logic [5:0] ADR_FULL   = 6'h14;
	// Control register fields
	localparam int CT_FULL  = 0;
	localparam int CT_DON   = 1;
	localparam int CT_INV   = 2;
	localparam int CT_ALL   = 3;
	localparam int CT_OSC   = 4;
	localparam int CT_PSAVE = 5;
	localparam int CT_FCAL  = 6;
	localparam int CT_HV    = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0020;
	// Address register fields
	localparam int AD_COL  = 0;
	localparam int AD_BANK = 8;
	localparam int AD_CMAX = 16;
	localparam int AD_BMAX = 24;
	localparam logic [6:0] COL_MAX_RST  = 7'h7F;
	localparam logic [3:0] BANK_MAX_RST = 4'h9;
	// Line register fields
	localparam int LN_START = 0;
	localparam int LN_ROW   = 8;
	localparam int LN_PART  = 16;
	localparam logic [6:0] ICON_LINE_MAX = 7'h4E;
	localparam logic [6:0] PART_80   = 7'h50;
	localparam logic [6:0] PART_64   = 7'h40;
	localparam logic [6:0] PART_16   = 7'h10;
	localparam logic [6:0] STEP8_MSK  = 7'h78;
	localparam logic [6:0] STEP16_MSK = 7'h70;
	// Basic register fields
	localparam int BS_VPR  = 0;
	localparam int BS_VOLTAGE_PROGRAM_OFFSET = 8;
	localparam int BS_PUMP = 12;
	// Full register fields
	localparam int FS_TC   = 0;
	localparam int FS_MP   = 4;
	localparam int FS_ICON = 5;
	localparam int FS_PUMP = 8;
	localparam logic [2:0] TC_RST    = 3'h2;
	localparam logic [2:0] TC_FIXED  = 3'h2;
	localparam logic [2:0] FPUMP_RST = 3'h4;
	// Status fields
	localparam int ST_VAR   = 0;
	localparam int ST_MAKER = 2;
	localparam int ST_INIT  = 5;
	localparam int ST_DON   = 6;
	localparam int ST_BUSY  = 7;
	localparam int ST_TRIM  = 8;
	// Start-up time after reset
	localparam int INIT_NS  = 100;
	localparam int CLK_NS   = 10;
	localparam logic [7:0] INIT_CYC = 8'((INIT_NS + CLK_NS - 1) / CLK_NS);
	typedef struct packed {
		logic osc_run;
		logic hv_en;
		logic grounded;
		logic disp_on;
		logic inverse;
		logic all_lit;
	} lcc_mode_s;
	typedef enum logic [2:0] {
		VS_IDLE = 3'b001,
		VS_PR   = 3'b010,
		VS_OFF  = 3'b100
	} lcc_vseq_e;
endpackage

// ===== tb/lcc_core_assertions.sv
// Checker: port-level properties of the command control
`timescale 1ns/1ps
module lcc_core_checker
	import lcc_pkg::*;
(
	input wire logic           clk,
	input wire logic           rstn,
	input wire logic           wb_cyc_i,
	input wire logic           wb_stb_i,
	input wire logic           wb_we_i,
	input wire logic [5:0]     wb_adr_i,
	input wire logic [3:0]     wb_sel_i,
	input wire logic [31:0]    wb_dat_i,
	input wire logic [31:0]    wb_dat_o,
	input wire logic           wb_ack_o,
	input wire logic [2:0]     maker_code_field,
	input wire logic           row_count_variant,
	input wire logic [4:0]     voltage_trim_input,
	input wire lcc_pkg::lcc_mode_s mode,
	input wire logic           frame_cal_run,
	input wire logic signed [5:0] trim_value
);
	import lcc_pkg::*;
	logic [4:0] up_q;
	logic       take;
	logic       wr_ctrl;
	logic       rd_st;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Cycles since reset, saturating
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			up_q <= 5'h00;
		end else if (up_q != 5'h1F) begin
			up_q <= up_q + 5'h01;
		end
	end
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ctrl = take && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0]
		&& wb_sel_i[1] && up_q > 5'h0F;
	assign rd_st = take && !wb_we_i && wb_adr_i == ADR_STATUS && up_q > 5'h04;
	ack_one_cycle_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");
	init_means_busy_a: assert property (rd_st |=>
		!wb_dat_o[ST_INIT] || wb_dat_o[ST_BUSY])
		else $error("init shown without busy");
	status_ident_a: assert property (rd_st |=>
		wb_dat_o[ST_MAKER+:3] == maker_code_field
		&& wb_dat_o[ST_VAR] == row_count_variant)
		else $error("status maker or variant wrong");
	trim_signed_a: assert property ($stable(voltage_trim_input) [*6] |->
		trim_value == {voltage_trim_input[4], voltage_trim_input})
		else $error("trim not sign extended");
	hv_needs_osc_a: assert property (mode.hv_en |-> mode.osc_run)
		else $error("generator on without oscillator");
	disp_needs_osc_a: assert property (mode.disp_on |->
		mode.osc_run && !mode.grounded)
		else $error("display on while stopped or grounded");
	psave_dark_a: assert property (wr_ctrl && wb_dat_i[CT_PSAVE] |->
		##3 mode.grounded && !mode.osc_run && !mode.hv_en && !mode.disp_on)
		else $error("power save did not darken");
	hv_off_a: assert property (wr_ctrl && wb_dat_i[CT_HV+:2] == 2'h0 |->
		##3 !mode.hv_en)
		else $error("generator on with power code zero");
	fcal_follow_a: assert property (wr_ctrl |->
		##3 frame_cal_run == $past(wb_dat_i[CT_FCAL], 3))
		else $error("calibration run mismatch");
	cover property (wr_ctrl && wb_dat_i[CT_PSAVE]);
	cover property (rd_st);
	cover property (mode.disp_on && mode.all_lit);
endmodule
bind lcc_core lcc_core_checker chk_u (.clk, .rstn, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.maker_code_field, .row_count_variant, .voltage_trim_input, .mode,
	.frame_cal_run, .trim_value);

// ===== tb/lcc_host_model.sv
// Host model: Wishbone classic master with command helpers
`timescale 1ns/1ps
module lcc_host_model
	import lcc_pkg::*;
(
	input  wire logic        clk,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [5:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat_w,
	input  wire logic        ack,
	input  wire logic [31:0] dat_r
);
	import lcc_pkg::*;
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 6'h00;
		sel = 4'hF;
		dat_w = 32'h0;
	end
	task automatic xfer(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat_w <= d;
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		adr <= ~a;
		dat_w <= ~d;
		@(posedge clk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask
	// Poll until neither busy nor init shows
	task automatic wait_ready();
		logic [31:0] q;
		q = 32'hFFFF_FFFF;
		while (q[ST_BUSY] !== 1'b0 || q[ST_INIT] !== 1'b0) begin
			rd(ADR_STATUS, q);
		end
	endtask
	// Program value, then offset; caller sends the next command
	task automatic set_voltage(input logic [31:0] pr, input logic [31:0] off);
		wr(ADR_BASIC, pr);
		wr(ADR_BASIC, off);
	endtask
endmodule

// ===== tb/lcc_core_tb.sv
// Testbench: command control driven through the host model
`timescale 1ns/1ps
module lcc_core_tb;
	import lcc_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, row_count_variant;
	logic ram_write_strobe, frame_cal_run, rows_p4;
	logic [5:0] wb_adr_i;
	logic [3:0] wb_sel_i, bank_addr;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [2:0] maker_code_field, temp_coefficient, pump_factor;
	logic [2:0] voltage_program_offset;
	logic [4:0] voltage_trim_input;
	logic [7:0] lcd_voltage_program;
	logic signed [5:0] trim_value;
	logic [6:0] col_addr;
	lcc_mode_s mode;
	int errors, samples_checked, cycles;
	logic [31:0] ct [7] = '{32'h110, 32'h010, 32'h300, 32'h118, 32'h116,
		32'h11E, 32'h13E};
	logic [5:0] ex [7] = '{6'h30, 6'h20, 6'h00, 6'h08, 6'h36, 6'h35, 6'h08};
	logic [5:0] mk [7] = '{6'h30, 6'h30, 6'h30, 6'h38, 6'h3F, 6'h3D, 6'h3C};
	lcc_core dut_u (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .maker_code_field,
		.row_count_variant, .voltage_trim_input, .ram_write_strobe, .mode,
		.frame_cal_run, .rows_p4, .temp_coefficient, .pump_factor,
		.lcd_voltage_program, .voltage_program_offset, .trim_value, .col_addr,
		.bank_addr);
	lcc_host_model host_u (.clk, .cyc(wb_cyc_i), .stb(wb_stb_i), .we(wb_we_i),
		.adr(wb_adr_i), .sel(wb_sel_i), .dat_w(wb_dat_i), .ack(wb_ack_o),
		.dat_r(wb_dat_o));
	task automatic give_verdict();
		if (errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pulse();
		ram_write_strobe <= 1'b1;
		@(posedge clk);
		ram_write_strobe <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		maker_code_field = 3'h5;
		row_count_variant = 1'b1;
		voltage_trim_input = 5'h10;
		ram_write_strobe = 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
		host_u.wr(ADR_CTRL, 32'h10);
		host_u.rd(ADR_STATUS, q);
		check("init", 32'h1, {31'h0, q[ST_INIT]});
		host_u.wait_ready();
		host_u.rd(ADR_STATUS, q);
		check("status", 32'h3015, q);
		check("trim", 32'h30, {26'h0, trim_value});
		host_u.rd(ADR_CTRL, q);
		check("ctrl", 32'h20, q);
		host_u.rd(ADR_LINE, q);
		check("line", 32'h0050_0000, q);
		check("outs", 32'h0840_0000, {2'h0, mode, frame_cal_run,
			pump_factor, lcd_voltage_program, voltage_program_offset,
			9'h0});
		for (int i = 0; i < 7; i++) begin
			host_u.wr(ADR_CTRL, ct[i]);
			repeat (2) @(posedge clk);
			check("mode", {26'h0, ex[i] & mk[i]},
				{26'h0, mode & mk[i]});
		end
		for (int b = 1; b >= 0; b--) begin
			host_u.wr(ADR_CTRL, b[0] ? 32'h40 : 32'h0);
			repeat (2) @(posedge clk);
			check("fcal", 32'(b[0]), {31'h0, frame_cal_run});
		end
		host_u.wr(ADR_FULL, 32'h435);
		host_u.rd(ADR_FULL, q);
		check("full_ign", 32'h402, q);
		check("tc", 32'h2, {29'h0, temp_coefficient});
		host_u.set_voltage(32'h302A, 32'h352A);
		check("vpr_wait", 32'h0, {24'h0, lcd_voltage_program});
		host_u.wr(ADR_ADDR, 32'h0906_0205);
		repeat (2) @(posedge clk);
		check("vpr", 32'h2ABC, {16'h0, lcd_voltage_program,
			voltage_program_offset, pump_factor, 2'h0});
		host_u.wr(ADR_CTRL, 32'h1);
		host_u.wr(ADR_BASIC, 32'h0);
		host_u.rd(ADR_BASIC, q);
		check("basic_ign", 32'h352A, q);
		host_u.wr(ADR_FULL, 32'h435);
		repeat (2) @(posedge clk);
		check("tc_p4", 32'hB, {28'h0, temp_coefficient, rows_p4});
		host_u.wr(ADR_LINE, 32'h002F_7F7F);
		host_u.rd(ADR_LINE, q);
		check("icon_line", 32'h0020_4E4E, q);
		repeat (2) @(posedge clk);
		check("p4_off", 32'h0, {31'h0, rows_p4});
		host_u.wr(ADR_FULL, 32'h415);
		host_u.wr(ADR_LINE, 32'h002F_7F7F);
		host_u.rd(ADR_LINE, q);
		check("line8", 32'h0028_7F7F, q);
		pulse();
		check("col", 32'h6, {25'h0, col_addr});
		pulse();
		check("col_wrap", 32'h0, {25'h0, col_addr});
		check("bank", 32'h3, {28'h0, bank_addr});
		host_u.rd(6'h3C, q);
		check("unmapped", 32'h0, q);
		give_verdict();
	end
endmodule
